// ---- lpcd_defs.svh ----
`ifndef LPCD_DEFS_SVH
`define LPCD_DEFS_SVH

// Reference clock period and timing figures in nanoseconds
`define LPCD_CLK_NS 40
`define LPCD_TRP_NS 20
`define LPCD_REFRESH_CYCLE_TIME_NS 80
`define LPCD_MODE_LOAD_DELAY_NS 20
// Least times round up to whole reference clock cycles
`define LPCD_TRP_CYC ((`LPCD_TRP_NS + `LPCD_CLK_NS - 1) / `LPCD_CLK_NS)
`define LPCD_REFRESH_CYCLE_TIME_CYC ((`LPCD_REFRESH_CYCLE_TIME_NS + `LPCD_CLK_NS - 1) / `LPCD_CLK_NS)
`define LPCD_MODE_LOAD_DELAY_CYC ((`LPCD_MODE_LOAD_DELAY_NS + `LPCD_CLK_NS - 1) / `LPCD_CLK_NS)

// Burst length in data words and in link clock edges
`define LPCD_BURST_LEN 4
`define LPCD_BURST_CK (`LPCD_BURST_LEN / 2)

// Widths
`define LPCD_ADDR_W 14
`define LPCD_DQ_W 16
`define LPCD_DM_W 2
`define LPCD_BANKS 4
`define LPCD_CNT_W 8

// Bit positions inside the synchronised pin vector
`define LPCD_P_CK 0
`define LPCD_P_CK_N 1
`define LPCD_P_CS_N 2
`define LPCD_P_RAS_N 3
`define LPCD_P_CAS_N 4
`define LPCD_P_WE_N 5
`define LPCD_P_CKE 6
`define LPCD_P_BA 7
`define LPCD_P_ADDR 9
`define LPCD_P_DM 23
`define LPCD_P_DQ 25
`define LPCD_PIN_W 41
`define LPCD_AP_BIT 10

// Reset value of the pin vector: deselected, clock enable high, clock high
`define LPCD_PIN_RST 41'h000_0000_007D

`endif

// ---- lpcd_pkg.sv ----
`default_nettype none
package lpcd_pkg;

  // Decoded command seen on one rising edge of the link clock
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_BST,
    CMD_PRE,
    CMD_PRE_ALL,
    CMD_AREF,
    CMD_SREF,
    CMD_DPD,
    CMD_LMR
  } lpcd_cmd_t;

  // Device wide operating mode
  typedef enum logic [1:0] {
    MD_NORMAL,
    MD_BUSY,
    MD_SELF_REF,
    MD_DEEP_PD
  } lpcd_mode_t;

endpackage : lpcd_pkg
`default_nettype wire

// ---- lpcd_bank_if.sv ----
`default_nettype none
interface lpcd_bank_if;
  logic act;
  logic [1:0] act_bank;
  logic [3:0] pre_mask;
  logic [3:0] open;
  logic [3:0] idle;

  modport ctl (output act, output act_bank, output pre_mask,
               input open, input idle);
  modport bank (input act, input act_bank, input pre_mask,
                output open, output idle);
endinterface : lpcd_bank_if
`default_nettype wire

// ---- lpcd_bank_track.sv ----
`include "lpcd_defs.svh"
`default_nettype none
module lpcd_bank_track (
  input wire logic i_ref_clk, // 25 MHz reference clock
  input wire logic i_resetn,  // Synchronous reset, active low
  lpcd_bank_if.bank bif       // Activate and precharge requests
);

  ////////////////////////////////////////////////////////////////////////
  // Per-bank row state: idle, row open, or precharging
  genvar g;
  generate
    for (g = 0; g < `LPCD_BANKS; g++) begin : g_bank
      logic [`LPCD_CNT_W-1:0] cnt_q;
      // Precharging is the state where neither open nor idle is set
      always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
          bif.open[g] <= 1'b0;
          bif.idle[g] <= 1'b1;
          cnt_q <= 8'h00;
        end else if (bif.pre_mask[g] && !bif.idle[g]) begin
          bif.open[g] <= 1'b0;
          bif.idle[g] <= 1'b0;
          cnt_q <= `LPCD_CNT_W'(`LPCD_TRP_CYC);
        end else if (bif.act && bif.act_bank == 2'(g) && bif.idle[g]) begin
          // Activate only counts on an idle bank
          bif.open[g] <= 1'b1;
          bif.idle[g] <= 1'b0;
        end else if (!bif.open[g] && !bif.idle[g]) begin
          if (cnt_q <= 8'h01) begin
            bif.idle[g] <= 1'b1;
            cnt_q <= 8'h00;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      end
    end
  endgenerate

endmodule : lpcd_bank_track
`default_nettype wire

// ---- lpcd_decoder.sv ----
`include "lpcd_defs.svh"
`default_nettype none
module lpcd_decoder (
  input wire logic i_ref_clk,                       // 25 MHz clock
  input wire logic i_resetn,                        // Sync reset, low
  input wire logic i_ck,                            // Link clock, true
  input wire logic i_ck_n,                          // Link clock, compl.
  input wire logic i_cs_n,                          // Select, low
  input wire logic i_ras_n,                         // Row strobe, low
  input wire logic i_cas_n,                         // Column strobe, low
  input wire logic i_we_n,                          // Write strobe, low
  input wire logic i_cke,                           // Clock enable
  input wire logic [1:0] i_bank_select_lines,       // Bank select
  input wire logic [`LPCD_ADDR_W-1:0] i_addr,       // Address lines
  input wire logic [`LPCD_DM_W-1:0] i_byte_write_mask, // Mask, high skips
  input wire logic [`LPCD_DQ_W-1:0] i_dq,           // Write data
  output var lpcd_pkg::lpcd_cmd_t o_cmd,            // Last command
  output logic o_cmd_valid,                         // Command pulse
  output logic [1:0] o_bank,                        // Command bank
  output logic [`LPCD_ADDR_W-1:0] o_addr,           // Row, column, op-code
  output logic o_auto_precharge,                    // Access auto-precharge
  output logic [3:0] o_bank_open,                   // Row open per bank
  output logic [3:0] o_bank_idle,                   // Idle per bank
  output logic o_rd_active,                         // Read burst running
  output logic o_rd_trunc,                          // Read cut short pulse
  output logic o_wr_valid,                          // Write word pulse
  output logic [`LPCD_DQ_W-1:0] o_wr_data,          // Write word
  output logic [`LPCD_DM_W-1:0] o_wr_byte_en,       // Bytes to store
  output logic o_self_refresh,                      // In self-refresh
  output logic o_deep_power_down,                   // In deep power-down
  output logic o_array_powered,                     // Array has power
  output logic o_busy,                              // Refresh/mode/pre-all
  output logic [`LPCD_ADDR_W-1:0] o_refresh_row     // Internal refresh row
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once two agree
  logic [`LPCD_PIN_W-1:0] pin_raw;
  logic [`LPCD_PIN_W-1:0] s1_q;
  logic [`LPCD_PIN_W-1:0] s2_q;
  logic [`LPCD_PIN_W-1:0] s3_q;
  logic [`LPCD_PIN_W-1:0] lvl_q;

  assign pin_raw = {i_dq, i_byte_write_mask, i_addr, i_bank_select_lines,
                    i_cke, i_we_n, i_cas_n, i_ras_n, i_cs_n, i_ck_n, i_ck};

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      s1_q <= `LPCD_PIN_RST;
      s2_q <= `LPCD_PIN_RST;
      s3_q <= `LPCD_PIN_RST;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accepted level per pin; a single odd sample is filtered out
  genvar g;
  generate
    for (g = 0; g < `LPCD_PIN_W; g++) begin : g_filt
      always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
          lvl_q[g] <= 1'(`LPCD_PIN_RST >> g);
        end else if (s2_q[g] == s3_q[g]) begin
          lvl_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Named views of the filtered pins
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic [1:0] ba;
  logic [`LPCD_ADDR_W-1:0] addr;
  logic [`LPCD_DM_W-1:0] dm;
  logic [`LPCD_DQ_W-1:0] dq;
  logic ck_hi;

  assign cs_n = lvl_q[`LPCD_P_CS_N];
  assign ras_n = lvl_q[`LPCD_P_RAS_N];
  assign cas_n = lvl_q[`LPCD_P_CAS_N];
  assign we_n = lvl_q[`LPCD_P_WE_N];
  assign cke = lvl_q[`LPCD_P_CKE];
  assign ba = lvl_q[`LPCD_P_BA +: 2];
  assign addr = lvl_q[`LPCD_P_ADDR +: `LPCD_ADDR_W];
  assign dm = lvl_q[`LPCD_P_DM +: `LPCD_DM_W];
  assign dq = lvl_q[`LPCD_P_DQ +: `LPCD_DQ_W];
  // Positive edge is true clock high with complement low
  assign ck_hi = lvl_q[`LPCD_P_CK] & ~lvl_q[`LPCD_P_CK_N];

  ////////////////////////////////////////////////////////////////////////
  // Link clock edge finder and clock enable history
  logic ck_hi_q;
  logic ck_rise;
  logic cke_prev_q;

  assign ck_rise = ck_hi & ~ck_hi_q;

  // Previous clock enable is the value seen on the last rising edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ck_hi_q <= 1'b1;
      cke_prev_q <= 1'b1;
    end else begin
      ck_hi_q <= ck_hi;
      if (ck_rise) begin
        cke_prev_q <= cke;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  lpcd_pkg::lpcd_mode_t mode_q;
  lpcd_pkg::lpcd_cmd_t cmd_d;
  logic run;
  logic enter;

  // Commands run with clock enable high on both edges; low now means entry
  assign run = cke & cke_prev_q;
  assign enter = ~cke & cke_prev_q;

  // Busy, self-refresh and deep power-down take no command at all
  always_comb begin
    cmd_d = lpcd_pkg::CMD_NONE;
    if (ck_rise && !cs_n && mode_q == lpcd_pkg::MD_NORMAL) begin
      unique case ({ras_n, cas_n, we_n})
        3'b111: cmd_d = lpcd_pkg::CMD_NONE;
        3'b011: if (run) cmd_d = lpcd_pkg::CMD_ACT;
        3'b101: if (run) cmd_d = lpcd_pkg::CMD_READ;
        3'b100: if (run) cmd_d = lpcd_pkg::CMD_WRITE;
        3'b110: begin
          if (run) cmd_d = lpcd_pkg::CMD_BST;
          else if (enter) cmd_d = lpcd_pkg::CMD_DPD;
        end
        3'b010: begin
          if (run) begin
            cmd_d = addr[`LPCD_AP_BIT] ? lpcd_pkg::CMD_PRE_ALL
                                       : lpcd_pkg::CMD_PRE;
          end
        end
        3'b001: begin
          if (run) cmd_d = lpcd_pkg::CMD_AREF;
          else if (enter) cmd_d = lpcd_pkg::CMD_SREF;
        end
        3'b000: if (run) cmd_d = lpcd_pkg::CMD_LMR;
      endcase
    end
  end

  // Command report; address is row, column or op-code per command
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_cmd <= lpcd_pkg::CMD_NONE;
      o_cmd_valid <= 1'b0;
      o_bank <= 2'h0;
      o_addr <= 14'h0000;
      o_auto_precharge <= 1'b0;
    end else begin
      o_cmd_valid <= (cmd_d != lpcd_pkg::CMD_NONE);
      if (cmd_d != lpcd_pkg::CMD_NONE) begin
        o_cmd <= cmd_d;
        o_bank <= ba;
        o_addr <= addr;
        o_auto_precharge <= (cmd_d == lpcd_pkg::CMD_READ ||
                             cmd_d == lpcd_pkg::CMD_WRITE) &&
                            addr[`LPCD_AP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read and write burst tracking, counted in link clock edges
  logic [2:0] rd_cnt_q;
  logic [1:0] rd_bank_q;
  logic rd_ap_q;
  logic [2:0] wr_cnt_q;
  logic [1:0] wr_bank_q;
  logic wr_ap_q;
  logic rd_end;
  logic wr_end;

  assign rd_end = ck_rise && rd_cnt_q == 3'h1 &&
                  cmd_d != lpcd_pkg::CMD_READ && cmd_d != lpcd_pkg::CMD_BST;
  assign wr_end = ck_rise && wr_cnt_q == 3'h1 &&
                  cmd_d != lpcd_pkg::CMD_WRITE && cmd_d != lpcd_pkg::CMD_READ;

  // A new read restarts the burst; terminate cuts the latest read
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rd_cnt_q <= 3'h0;
      rd_bank_q <= 2'h0;
      rd_ap_q <= 1'b0;
      o_rd_trunc <= 1'b0;
    end else begin
      o_rd_trunc <= 1'b0;
      if (cmd_d == lpcd_pkg::CMD_READ) begin
        rd_cnt_q <= 3'(`LPCD_BURST_CK);
        rd_bank_q <= ba;
        rd_ap_q <= addr[`LPCD_AP_BIT];
      end else if (cmd_d == lpcd_pkg::CMD_BST) begin
        // Whatever its bank; the row is left open
        rd_cnt_q <= 3'h0;
        o_rd_trunc <= (rd_cnt_q != 3'h0);
      end else if (ck_rise && rd_cnt_q != 3'h0) begin
        rd_cnt_q <= rd_cnt_q - 3'h1;
      end
    end
  end

  // A read also cuts a running write short
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wr_cnt_q <= 3'h0;
      wr_bank_q <= 2'h0;
      wr_ap_q <= 1'b0;
    end else if (cmd_d == lpcd_pkg::CMD_WRITE) begin
      wr_cnt_q <= 3'(`LPCD_BURST_CK);
      wr_bank_q <= ba;
      wr_ap_q <= addr[`LPCD_AP_BIT];
    end else if (cmd_d == lpcd_pkg::CMD_READ) begin
      wr_cnt_q <= 3'h0;
    end else if (ck_rise && wr_cnt_q != 3'h0) begin
      wr_cnt_q <= wr_cnt_q - 3'h1;
    end
  end

  // One data word per edge after the write; mask high drops the byte
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_wr_valid <= 1'b0;
      o_wr_data <= 16'h0000;
      o_wr_byte_en <= 2'h0;
      o_rd_active <= 1'b0;
    end else begin
      o_wr_valid <= ck_rise && wr_cnt_q != 3'h0;
      if (ck_rise && wr_cnt_q != 3'h0) begin
        o_wr_data <= dq;
        o_wr_byte_en <= ~dm;
      end
      o_rd_active <= (rd_cnt_q != 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank tracker requests
  lpcd_bank_if bif ();

  // Auto-precharge fires as the burst ends; plain access keeps the row
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      bif.act <= 1'b0;
      bif.act_bank <= 2'h0;
      bif.pre_mask <= 4'h0;
    end else begin
      bif.act <= (cmd_d == lpcd_pkg::CMD_ACT);
      bif.act_bank <= ba;
      bif.pre_mask <= ({4{cmd_d == lpcd_pkg::CMD_PRE_ALL ||
                          cmd_d == lpcd_pkg::CMD_DPD}})
                    | ({4{cmd_d == lpcd_pkg::CMD_PRE}} & (4'h1 << ba))
                    | ({4{rd_end && rd_ap_q}} & (4'h1 << rd_bank_q))
                    | ({4{wr_end && wr_ap_q}} & (4'h1 << wr_bank_q));
    end
  end

  lpcd_bank_track u_bank (
    .i_ref_clk (i_ref_clk),
    .i_resetn (i_resetn),
    .bif (bif.bank)
  );

  assign o_bank_open = bif.open;
  assign o_bank_idle = bif.idle;

  ////////////////////////////////////////////////////////////////////////
  // Device mode: busy windows, self-refresh and deep power-down
  logic [`LPCD_CNT_W-1:0] busy_cnt_q;

  // Clock enable exit is seen on the reference clock: the link may stop
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      mode_q <= lpcd_pkg::MD_NORMAL;
      busy_cnt_q <= 8'h00;
      o_refresh_row <= 14'h0000;
    end else begin
      unique case (mode_q)
        lpcd_pkg::MD_NORMAL: begin
          if (cmd_d == lpcd_pkg::CMD_AREF) begin
            mode_q <= lpcd_pkg::MD_BUSY;
            busy_cnt_q <= `LPCD_CNT_W'(`LPCD_REFRESH_CYCLE_TIME_CYC);
            o_refresh_row <= o_refresh_row + 14'h0001;
          end else if (cmd_d == lpcd_pkg::CMD_LMR) begin
            mode_q <= lpcd_pkg::MD_BUSY;
            busy_cnt_q <= `LPCD_CNT_W'(`LPCD_MODE_LOAD_DELAY_CYC);
          end else if (cmd_d == lpcd_pkg::CMD_PRE_ALL) begin
            mode_q <= lpcd_pkg::MD_BUSY;
            busy_cnt_q <= `LPCD_CNT_W'(`LPCD_TRP_CYC);
          end else if (cmd_d == lpcd_pkg::CMD_SREF) begin
            mode_q <= lpcd_pkg::MD_SELF_REF;
            busy_cnt_q <= `LPCD_CNT_W'(`LPCD_REFRESH_CYCLE_TIME_CYC);
          end else if (cmd_d == lpcd_pkg::CMD_DPD) begin
            mode_q <= lpcd_pkg::MD_DEEP_PD;
          end
        end
        lpcd_pkg::MD_BUSY: begin
          if (busy_cnt_q <= 8'h01) begin
            mode_q <= lpcd_pkg::MD_NORMAL;
            busy_cnt_q <= 8'h00;
          end else begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
          end
        end
        lpcd_pkg::MD_SELF_REF: begin
          // Rows advance internally; only clock enable is watched
          if (cke) begin
            mode_q <= lpcd_pkg::MD_NORMAL;
          end else if (busy_cnt_q <= 8'h01) begin
            busy_cnt_q <= `LPCD_CNT_W'(`LPCD_REFRESH_CYCLE_TIME_CYC);
            o_refresh_row <= o_refresh_row + 14'h0001;
          end else begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
          end
        end
        lpcd_pkg::MD_DEEP_PD: begin
          if (cke) begin
            mode_q <= lpcd_pkg::MD_NORMAL;
          end
        end
      endcase
    end
  end

  // Mode flags; array power drops in deep power-down, contents lost
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
      o_self_refresh <= 1'b0;
      o_deep_power_down <= 1'b0;
      o_array_powered <= 1'b1;
    end else begin
      o_busy <= (mode_q == lpcd_pkg::MD_BUSY);
      o_self_refresh <= (mode_q == lpcd_pkg::MD_SELF_REF);
      o_deep_power_down <= (mode_q == lpcd_pkg::MD_DEEP_PD);
      o_array_powered <= (mode_q != lpcd_pkg::MD_DEEP_PD);
    end
  end

endmodule : lpcd_decoder
`default_nettype wire

// ---- lpcd_ctl_model.sv ----
`default_nettype none
module lpcd_ctl_model (
  output logic o_ck,          // Link clock, true
  output logic o_ck_n,        // Link clock, complement
  output logic o_cs_n,        // Select, low
  output logic o_ras_n,       // Row strobe, low
  output logic o_cas_n,       // Column strobe, low
  output logic o_we_n,        // Write strobe, low
  output logic o_cke,         // Clock enable
  output logic [1:0] o_ba,    // Bank select lines
  output logic [13:0] o_addr, // Address lines
  output logic [1:0] o_dm,    // Byte write mask
  output logic [15:0] o_dq    // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  int wr_left;

  ////////////////////////////////////////
  // Free running link clock, phase unrelated to the reference clock
  initial begin
    o_ck = 1'b1;
    o_ck_n = 1'b0;
    #13;
    forever begin
      #160 o_ck = ~o_ck;
      o_ck_n = ~o_ck_n;
    end
  end

  // Idle pins: deselected, clock enable high
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_cke = 1'b1;
    o_ba = 2'h0;
    o_addr = 14'h0000;
    o_dm = 2'h0;
    o_dq = 16'h0000;
    wr_left = 0;
  end

  ////////////////////////////////////////
  // One command per link edge; pins change at the falling edge so they
  // sit half a period on each side of the sampling edge
  task send(input logic [3:0] c, input logic k, input logic [1:0] b,
            input logic [13:0] a, input logic [1:0] m,
            input logic [15:0] d);
    @(negedge o_ck);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
    o_cke <= k;
    o_ba <= b;
    o_addr <= a;
    // Data only on the two edges after a write; else it toggles so a
    // stale word can never pass for a fresh one
    if (wr_left > 0) begin
      o_dm <= m;
      o_dq <= d;
      wr_left--;
    end else begin
      o_dm <= ~o_dm;
      o_dq <= ~o_dq;
    end
    if (c == 4'h4 && k) begin
      wr_left = 2;
    end
    @(posedge o_ck);
  endtask : send
endmodule : lpcd_ctl_model
`default_nettype wire

// ---- lpcd_decoder_properties.sv ----
`include "lpcd_defs.svh"
`default_nettype none
module lpcd_decoder_chk (
  input wire logic i_ref_clk,                // Reference clock
  input wire logic i_resetn,                 // Sync reset, low
  input var lpcd_pkg::lpcd_cmd_t o_cmd,      // Last command
  input wire logic o_cmd_valid,              // Command pulse
  input wire logic [1:0] o_bank,             // Command bank
  input wire logic [`LPCD_ADDR_W-1:0] o_addr, // Command address
  input wire logic o_auto_precharge,         // Auto-precharge flag
  input wire logic [3:0] o_bank_open,        // Open rows
  input wire logic [3:0] o_bank_idle,        // Idle banks
  input wire logic o_rd_active,              // Read running
  input wire logic o_rd_trunc,               // Read cut pulse
  input wire logic o_self_refresh,           // Self-refresh
  input wire logic o_deep_power_down,        // Deep power-down
  input wire logic o_array_powered,          // Array power
  input wire logic o_busy                    // Busy window
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////
  pulse_once_a: assert property (
    o_cmd_valid |=> !o_cmd_valid) else $error("command pulse too long");
  ap_flag_a: assert property (
    o_cmd_valid && (o_cmd == lpcd_pkg::CMD_READ ||
    o_cmd == lpcd_pkg::CMD_WRITE) |->
    o_auto_precharge == o_addr[`LPCD_AP_BIT])
    else $error("auto-precharge flag wrong");
  act_opens_a: assert property (
    o_cmd_valid && o_cmd == lpcd_pkg::CMD_ACT |->
    ##[1:2] o_bank_open[o_bank]) else $error("activate left row shut");
  pre_closes_a: assert property (
    o_cmd_valid && o_cmd == lpcd_pkg::CMD_PRE |->
    ##[1:2] !o_bank_open[o_bank]) else $error("precharge left row open");
  pre_all_a: assert property (
    o_cmd_valid && o_cmd == lpcd_pkg::CMD_PRE_ALL |->
    ##[1:2] o_bank_open == 4'h0) else $error("precharge all missed");
  idle_after_a: assert property (
    o_cmd_valid && o_cmd == lpcd_pkg::CMD_PRE_ALL |->
    ##[1:4] o_bank_idle == 4'hF) else $error("banks not idle");
  ap_read_a: assert property (
    o_cmd_valid && o_cmd == lpcd_pkg::CMD_READ && o_auto_precharge |->
    ##[2:30] !o_bank_open[o_bank]) else $error("auto-precharge missed");
  trunc_keeps_a: assert property (
    o_rd_trunc |=> o_bank_open == $past(o_bank_open))
    else $error("terminate closed a row");
  trunc_ends_a: assert property (
    o_rd_trunc |-> ##[0:2] !o_rd_active) else $error("read not cut");
  sleep_deaf_a: assert property (
    o_self_refresh || o_deep_power_down |-> !o_cmd_valid)
    else $error("command taken while asleep");
  dpd_power_a: assert property (
    o_deep_power_down |-> !o_array_powered && o_bank_open == 4'h0)
    else $error("array powered in deep power-down");
  aref_busy_a: assert property (
    o_cmd_valid && o_cmd == lpcd_pkg::CMD_AREF |-> ##[0:2] o_busy)
    else $error("refresh not busy");
endmodule : lpcd_decoder_chk

bind lpcd_decoder lpcd_decoder_chk i_lpcd_decoder_chk (
  .i_ref_clk, .i_resetn, .o_cmd, .o_cmd_valid, .o_bank, .o_addr,
  .o_auto_precharge, .o_bank_open, .o_bank_idle, .o_rd_active,
  .o_rd_trunc, .o_self_refresh, .o_deep_power_down, .o_array_powered,
  .o_busy);
`default_nettype wire

// ---- lpcd_decoder_tb.sv ----
`include "lpcd_defs.svh"
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("MISMATCH %s exp %0h got %0h", name, exp, got); \
    end \
  end
module lpcd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] c; logic [1:0] b; logic [13:0] a;
    lpcd_pkg::lpcd_cmd_t e; int n; logic [3:0] op;} lpcd_row_t;
  logic clk, resetn, ck, ck_n, cs_n, ras_n, cas_n, we_n, cke;
  logic [1:0] ba, dm, bank, wr_en, seen_bank;
  logic [13:0] addr, addr_out, seen_addr, ref_row;
  logic [15:0] dq, wr_data;
  logic [3:0] open, idle;
  logic cmd_valid, ap, rd_act, rd_trunc, wr_valid, sref, deep_power_down, pwr, busy;
  lpcd_pkg::lpcd_cmd_t cmd_out, seen_cmd;
  int err_total, n_tests, seen_n, n_trunc, cyc, n0;
  logic [15:0] wd[$];
  logic [1:0] we[$];
  // Codes are {select, row, column, write}, all active low
  lpcd_row_t rows[10] = '{
    '{4'h3, 2'h1, 14'h1234, lpcd_pkg::CMD_ACT, 1, 4'h2},
    '{4'hB, 2'h2, 14'h0000, lpcd_pkg::CMD_NONE, 0, 4'h2},
    '{4'h7, 2'h2, 14'h0000, lpcd_pkg::CMD_NONE, 0, 4'h2},
    '{4'h5, 2'h1, 14'h0005, lpcd_pkg::CMD_READ, 1, 4'h2},
    '{4'h4, 2'h1, 14'h000A, lpcd_pkg::CMD_WRITE, 1, 4'h2},
    '{4'h2, 2'h1, 14'h0000, lpcd_pkg::CMD_PRE, 1, 4'h0},
    '{4'h1, 2'h0, 14'h0000, lpcd_pkg::CMD_AREF, 1, 4'h0},
    '{4'h0, 2'h2, 14'h0020, lpcd_pkg::CMD_LMR, 1, 4'h0},
    '{4'h3, 2'h3, 14'h3FFF, lpcd_pkg::CMD_ACT, 1, 4'h8},
    '{4'h2, 2'h0, 14'h0400, lpcd_pkg::CMD_PRE_ALL, 1, 4'h0}};

  lpcd_ctl_model i_lpcd_ctl_model (.o_ck(ck), .o_ck_n(ck_n),
    .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
    .o_cke(cke), .o_ba(ba), .o_addr(addr), .o_dm(dm), .o_dq(dq));

  lpcd_decoder i_lpcd_decoder (.i_ref_clk(clk), .i_resetn(resetn),
    .i_ck(ck), .i_ck_n(ck_n), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_cke(cke),
    .i_bank_select_lines(ba), .i_addr(addr), .i_byte_write_mask(dm),
    .i_dq(dq), .o_cmd(cmd_out), .o_cmd_valid(cmd_valid), .o_bank(bank),
    .o_addr(addr_out), .o_auto_precharge(ap), .o_bank_open(open),
    .o_bank_idle(idle), .o_rd_active(rd_act), .o_rd_trunc(rd_trunc),
    .o_wr_valid(wr_valid), .o_wr_data(wr_data), .o_wr_byte_en(wr_en),
    .o_self_refresh(sref), .o_deep_power_down(deep_power_down),
    .o_array_powered(pwr), .o_busy(busy), .o_refresh_row(ref_row));

  ////////////////////////////////////////
  task stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Mask 01 and word A55A go out on every write data edge
  task cmd(input logic [3:0] c, input logic k, input logic [1:0] b,
           input logic [13:0] a);
    i_lpcd_ctl_model.send(c, k, b, a, 2'h1, 16'hA55A);
  endtask : cmd

  task nops(input int n, input logic k);
    repeat (n) cmd(4'h7, k, 2'h0, 14'h0000);
  endtask : nops

  // Pins must sit idle with clock enable high around reset
  task rst_check();
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("idle", 4'hF, idle)
    `CHK("powered", 1'b1, pwr)
    `CHK("cmd", lpcd_pkg::CMD_NONE, cmd_out)
    `CHK("ref_row", 14'h0000, ref_row)
    @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : rst_check

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Record decoded commands, cut reads and write words as they appear
  always @(posedge clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      seen_n++;
      seen_cmd = cmd_out;
      seen_bank = bank;
      seen_addr = addr_out;
    end
    if (rd_trunc === 1'b1) begin
      n_trunc++;
    end
    if (wr_valid === 1'b1) begin
      wd.push_back(wr_data);
      we.push_back(wr_en);
    end
    // Whole run needs under a thousand cycles
    if (cyc == 6000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    rst_check();
    for (int i = 0; i < 10; i++) begin
      n0 = seen_n;
      cmd(rows[i].c, 1'b1, rows[i].b, rows[i].a);
      nops(3, 1'b1);
      `CHK("count", rows[i].n, seen_n - n0)
      if (rows[i].n == 1) begin
        `CHK("cmd", rows[i].e, seen_cmd)
        `CHK("bank", rows[i].b, seen_bank)
        `CHK("addr", rows[i].a, seen_addr)
      end
      `CHK("open", rows[i].op, open)
      `CHK("idle", ~rows[i].op, idle)
    end
    `CHK("ref_row", 14'h0001, ref_row)
    // Terminate right behind a plain read: read cut, row kept
    cmd(4'h3, 1'b1, 2'h0, 14'h0001);
    nops(1, 1'b1);
    cmd(4'h5, 1'b1, 2'h0, 14'h0000);
    cmd(4'h6, 1'b1, 2'h0, 14'h0000);
    nops(1, 1'b1);
    `CHK("rd_active", 1'b0, rd_act)
    nops(2, 1'b1);
    `CHK("trunc", 1, n_trunc)
    `CHK("open", 4'h1, open)
    cmd(4'h5, 1'b1, 2'h0, 14'h0400);
    nops(4, 1'b1);
    `CHK("ap", 1'b1, ap)
    `CHK("open", 4'h0, open)
    `CHK("idle", 4'hF, idle)
    // Write with auto-precharge closes its row once the data is in
    cmd(4'h3, 1'b1, 2'h1, 14'h0002);
    nops(1, 1'b1);
    cmd(4'h4, 1'b1, 2'h1, 14'h0400);
    nops(4, 1'b1);
    `CHK("ap", 1'b1, ap)
    `CHK("open", 4'h0, open)
    // Self-refresh entry, then an activate that must be ignored
    cmd(4'h1, 1'b1, 2'h0, 14'h0000);
    cmd(4'h1, 1'b0, 2'h0, 14'h0000);
    cmd(4'h3, 1'b0, 2'h1, 14'h0001);
    nops(2, 1'b0);
    `CHK("sref", 1'b1, sref)
    `CHK("open", 4'h0, open)
    nops(2, 1'b1);
    cmd(4'h1, 1'b1, 2'h0, 14'h0000);
    `CHK("sref", 1'b0, sref)
    // Terminate code with clock enable low drops the array
    cmd(4'h3, 1'b1, 2'h2, 14'h0002);
    nops(1, 1'b1);
    cmd(4'h6, 1'b0, 2'h0, 14'h0000);
    nops(2, 1'b0);
    `CHK("dpd", 1'b1, deep_power_down)
    `CHK("powered", 1'b0, pwr)
    `CHK("open", 4'h0, open)
    nops(3, 1'b1);
    rst_check();
    `CHK("words", 4, wd.size())
    for (int i = 0; i < wd.size(); i++) begin
      `CHK("wdata", 16'hA55A, wd[i])
      `CHK("byte_en", 2'h2, we[i])
    end
    stop_test();
  end
endmodule : lpcd_decoder_tb
`default_nettype wire
